/* File: design/ast_cfg.svh */
// ast_cfg.svh: offsets, reset values and timing counts of the serial transceiver
// assumes: included by bare name from the design and testbench files
`ifndef AST_CFG_SVH
`define AST_CFG_SVH

// register byte offsets on the axi4-lite port
`define AST_OFF_CTRL 8'h00
`define AST_OFF_BAUD 8'h04
`define AST_OFF_TXBUF 8'h08
`define AST_OFF_RXBUF 8'h0C
`define AST_OFF_STAT 8'h10

// reset values
`define AST_CTRL_RST 16'h0000
`define AST_BAUD_RST 16'h0000

// ticks of the baud divider per bit: normal and high speed
`define AST_TICKS_LO 5'h10
`define AST_TICKS_HI 5'h04

// last data bit index for eight and nine bit characters
`define AST_LAST8 4'h7
`define AST_LAST9 4'h8

// axi response codes
`define AST_RESP_OK 2'h0
`define AST_RESP_ERR 2'h2

`endif

/* File: design/ast_pkg.sv */
// ast_pkg.sv: types of the serial transceiver
// assumes: ast_cfg.svh holds the numeric constants
package ast_pkg;

    // control register layout, bit 0 first from the right
    typedef struct packed {
        logic [3:0] spare;
        logic rx_irq_enable;
        logic tx_irq_enable;
        logic baud_wide_counter;
        logic baud_high_speed;
        logic tx_polarity_invert;
        logic address_detect_enable;
        logic continuous_rx_enable;
        logic nine_bit_rx_select;
        logic nine_bit_tx;
        logic sync_select;
        logic tx_enable;
        logic port_enable;
    } ast_ctrl_s;

    // status register layout
    typedef struct packed {
        logic [1:0] spare;
        logic rx_ninth;
        logic framing_error;
        logic tx_shift_empty;
        logic overrun_error;
        logic rx_ready_flag;
        logic tx_buffer_empty_flag;
    } ast_stat_s;

    // transmit sequencer states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } ast_tx_e;

    // receive sequencer states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } ast_rx_e;

endpackage

/* File: design/ast_uart.sv */
// ast_uart.sv: asynchronous nrz transceiver with an axi4-lite register port
// assumes: rx_i is synchronous to aclk; master keeps one write and one read open
// Overview of operation
// R1: idle line rests at mark, nrz bits
// R2: start space, 8 or 9 data, stop mark
// R3: every bit lasts one baud period
// R4: divider runs with 8 or 16 bit count
// R5: data bits go least significant first
// R6: transmitter and receiver independent, shared format
// R7: no hardware parity, ninth bit is software's
// R8: transmitter runs only when enabled, asynchronous
// R9: buffer write starts sending, idle loads at once
// R10: queued character loads right after stop bit
// R11: polarity bit inverts transmitted idle and data
// R12: polarity acts only in asynchronous mode
// R13: empty flag clear only when busy and queued
// R14: enabling transmitter sets empty flag
// R15: empty flag valid second cycle after write
// R16: empty flag read only
// R17: flag sets regardless, request gated by enable
// R18: host drops transmit enable on last character
// R19: ready flag set on buffer load, request follows
// R20: status holds errors and ninth bit
// R21: clearing continuous receive clears overrun
// R22: host enables port, then continuous receive
// R23: address mode keeps only ninth-bit-set characters
// R24: start on falling edge, mid-bit sampling
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ast_cfg.svh"
`default_nettype none

module ast_uart
    import ast_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial line
    output logic tx_o,
    input wire logic rx_i,
    // interrupt requests
    output logic tx_irq,
    output logic rx_irq
);

    // merge written bytes into an old word
    function automatic logic [31:0] ast_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // divider reload: narrow count uses the low byte only
    function automatic logic [15:0] ast_div(input ast_ctrl_s c, input logic [15:0] b);
        return c.baud_wide_counter ? b : {8'h00, b[7:0]}; // R4
    endfunction

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, rd_data;
    logic rd_err, wr_err;
    logic aw_full_q, w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go, tx_wr, rx_rd;
    ast_ctrl_s ctrl_q;
    logic [15:0] baud_q, div;
    logic [31:0] ctrl_m, baud_m;
    logic [4:0] bticks, blast, bhalf;
    // transmit state
    ast_tx_e tx_st_q;
    logic [8:0] tx_buf_q, tx_shift_q;
    logic tx_full_q, tx_flag_q, tx_line_q, tx_line_d, tx_irq_q;
    logic [15:0] tx_pre_q;
    logic [4:0] tx_tick_q;
    logic [3:0] tx_bit_q, tx_lastbit;
    logic tx_active, tx_inv, tx_bend, tx_load;
    // receive state
    ast_rx_e rx_st_q;
    logic [8:0] rx_shift_q, rx_word;
    logic [7:0] rx_buf_q;
    logic rx_prev_q, rx_ready_q, rx_ninth_q, rx_ferr_q, overrun_q, rx_irq_q;
    logic [15:0] rx_pre_q;
    logic [4:0] rx_tick_q;
    logic [3:0] rx_bit_q, rx_lastbit;
    logic rx_active, rx_bend, rx_hend, rx_done, rx_ferr_d, rx_keep;
    ast_stat_s stat;

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign tx_o = tx_line_q;
    assign tx_irq = tx_irq_q;
    assign rx_irq = rx_irq_q;

    // bus decode terms
    assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_err = (aw_addr_q != `AST_OFF_CTRL) && (aw_addr_q != `AST_OFF_BAUD) &&
                    (aw_addr_q != `AST_OFF_TXBUF);
    assign tx_wr = wr_go & (aw_addr_q == `AST_OFF_TXBUF) & w_strb_q[0];
    assign rx_rd = arvalid & arready_q & (araddr == `AST_OFF_RXBUF);
    assign ctrl_m = ast_merge({16'h0000, ctrl_q}, w_data_q, w_strb_q);
    assign baud_m = ast_merge({16'h0000, baud_q}, w_data_q, w_strb_q);

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (awvalid && awready_q) begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= awaddr;
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end else if (!aw_full_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (wvalid && wready_q) begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (wr_go) begin
            w_full_q <= 1'b0;
        end else if (!w_full_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `AST_RESP_OK;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_err ? `AST_RESP_ERR : `AST_RESP_OK;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // control and divider registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `AST_CTRL_RST;
            baud_q <= `AST_BAUD_RST;
        end else if (wr_go && aw_addr_q == `AST_OFF_CTRL) begin
            ctrl_q <= ast_ctrl_s'(ctrl_m[15:0]);
        end else if (wr_go && aw_addr_q == `AST_OFF_BAUD) begin
            baud_q <= baud_m[15:0];
        end
    end

    // status word; flags have no write path
    always_comb begin
        stat = '0;
        stat.tx_buffer_empty_flag = tx_flag_q; // R16
        stat.rx_ready_flag = rx_ready_q;
        stat.overrun_error = overrun_q;
        stat.tx_shift_empty = (tx_st_q == TX_IDLE);
        stat.framing_error = rx_ferr_q; // R20
        stat.rx_ninth = rx_ninth_q;
    end

    // read data select
    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        case (araddr)
            `AST_OFF_CTRL: rd_data = {16'h0000, ctrl_q};
            `AST_OFF_BAUD: rd_data = {16'h0000, baud_q};
            `AST_OFF_TXBUF: rd_data = {23'h000000, tx_buf_q};
            `AST_OFF_RXBUF: rd_data = {24'h000000, rx_buf_q}; // R20
            `AST_OFF_STAT: rd_data = {24'h000000, stat};
            default: rd_err = 1'b1;
        endcase
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `AST_RESP_OK;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_err ? `AST_RESP_ERR : `AST_RESP_OK;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // shared format and rate terms
    assign div = ast_div(ctrl_q, baud_q); // R6
    assign bticks = ctrl_q.baud_high_speed ? `AST_TICKS_HI : `AST_TICKS_LO;
    assign blast = bticks - 5'h01;
    assign bhalf = (bticks >> 1) - 5'h01;

    // transmit control terms
    assign tx_active = ctrl_q.tx_enable & ~ctrl_q.sync_select & ctrl_q.port_enable; // R8
    assign tx_inv = ctrl_q.tx_polarity_invert & ~ctrl_q.sync_select; // R12
    assign tx_bend = (tx_pre_q == 16'h0000) && (tx_tick_q == blast); // R3
    assign tx_lastbit = ctrl_q.nine_bit_tx ? `AST_LAST9 : `AST_LAST8;
    assign tx_load = tx_active & tx_full_q & ((tx_st_q == TX_IDLE) | // R9
                     ((tx_st_q == TX_STOP) & tx_bend)); // R10

    // transmit buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buf_q <= 9'h000;
            tx_full_q <= 1'b0;
        end else if (!tx_active) begin
            tx_full_q <= 1'b0;
        end else begin
            if (tx_wr) begin
                tx_buf_q <= w_data_q[8:0]; // R7
            end
            tx_full_q <= (tx_full_q & ~tx_load) | tx_wr;
        end
    end

    // transmit sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st_q <= TX_IDLE;
            tx_shift_q <= 9'h000;
            tx_bit_q <= 4'h0;
        end else if (!tx_active) begin
            tx_st_q <= TX_IDLE;
        end else if (tx_load) begin
            tx_st_q <= TX_START;
            tx_shift_q <= tx_buf_q;
            tx_bit_q <= 4'h0;
        end else if (tx_bend) begin
            unique case (tx_st_q)
                TX_IDLE: tx_st_q <= TX_IDLE;
                TX_START: tx_st_q <= TX_DATA;
                TX_DATA: begin
                    tx_shift_q <= {1'b0, tx_shift_q[8:1]}; // R5
                    tx_bit_q <= tx_bit_q + 4'h1;
                    if (tx_bit_q == tx_lastbit) begin
                        tx_st_q <= TX_STOP; // R2
                    end
                end
                TX_STOP: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // transmit bit timer, restarted with each character
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pre_q <= 16'h0000;
            tx_tick_q <= 5'h00;
        end else if (tx_load || tx_st_q == TX_IDLE) begin
            tx_pre_q <= div;
            tx_tick_q <= 5'h00;
        end else if (tx_pre_q == 16'h0000) begin
            tx_pre_q <= div;
            tx_tick_q <= tx_bend ? 5'h00 : tx_tick_q + 5'h01;
        end else begin
            tx_pre_q <= tx_pre_q - 16'h0001;
        end
    end

    // line level: mark when idle or stopping, nrz data
    always_comb begin
        unique case (tx_st_q)
            TX_START: tx_line_d = 1'b0;
            TX_DATA: tx_line_d = tx_shift_q[0];
            default: tx_line_d = 1'b1; // R1
        endcase
    end

    // line output and transmit flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_line_q <= 1'b1;
            tx_flag_q <= 1'b0;
            tx_irq_q <= 1'b0;
        end else begin
            tx_line_q <= tx_line_d ^ tx_inv; // R11
            tx_flag_q <= tx_active & ~(tx_full_q & (tx_st_q != TX_IDLE)); // R13 R14 R15
            tx_irq_q <= tx_flag_q & ctrl_q.tx_irq_enable; // R17
        end
    end

    // receive control terms
    assign rx_active = ctrl_q.port_enable & ~ctrl_q.sync_select & ctrl_q.continuous_rx_enable;
    assign rx_bend = (rx_pre_q == 16'h0000) && (rx_tick_q == blast);
    assign rx_hend = (rx_pre_q == 16'h0000) && (rx_tick_q == bhalf);
    assign rx_lastbit = ctrl_q.nine_bit_rx_select ? `AST_LAST9 : `AST_LAST8;
    assign rx_done = (rx_st_q == RX_STOP) & rx_bend & rx_active;
    assign rx_ferr_d = ~rx_i;
    assign rx_word = ctrl_q.nine_bit_rx_select ? rx_shift_q : {1'b0, rx_shift_q[8:1]};
    assign rx_keep = ~(ctrl_q.address_detect_enable & ctrl_q.nine_bit_rx_select &
                       ~rx_word[8]); // R23

    // receive sequencer: edge start, half-bit check, then whole bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_st_q <= RX_IDLE;
            rx_prev_q <= 1'b1;
            rx_shift_q <= 9'h000;
            rx_bit_q <= 4'h0;
        end else begin
            rx_prev_q <= rx_i;
            if (!rx_active) begin
                rx_st_q <= RX_IDLE;
            end else begin
                unique case (rx_st_q)
                    RX_IDLE: if (rx_prev_q && !rx_i && !overrun_q) begin
                        rx_st_q <= RX_START; // R24
                    end
                    RX_START: if (rx_hend) begin
                        rx_st_q <= rx_i ? RX_IDLE : RX_DATA; // R24
                        rx_bit_q <= 4'h0;
                    end
                    RX_DATA: if (rx_bend) begin
                        rx_shift_q <= {rx_i, rx_shift_q[8:1]}; // R5
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == rx_lastbit) begin
                            rx_st_q <= RX_STOP;
                        end
                    end
                    RX_STOP: if (rx_bend) begin
                        rx_st_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // receive bit timer, restarted on each start edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pre_q <= 16'h0000;
            rx_tick_q <= 5'h00;
        end else if (rx_st_q == RX_IDLE || (rx_st_q == RX_START && rx_hend)) begin
            rx_pre_q <= div;
            rx_tick_q <= 5'h00;
        end else if (rx_pre_q == 16'h0000) begin
            rx_pre_q <= div;
            rx_tick_q <= rx_bend ? 5'h00 : rx_tick_q + 5'h01;
        end else begin
            rx_pre_q <= rx_pre_q - 16'h0001;
        end
    end

    // receive buffer and ready flag; a read does not free the buffer for a character ending in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buf_q <= 8'h00;
            rx_ninth_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_ready_q <= 1'b0;
        end else if (rx_done && !rx_ready_q && rx_keep) begin
            rx_buf_q <= rx_word[7:0]; // R20
            rx_ninth_q <= rx_word[8];
            rx_ferr_q <= rx_ferr_d;
            rx_ready_q <= 1'b1; // R19
        end else if (rx_rd) begin
            rx_ready_q <= 1'b0;
        end
    end

    // overrun flag and receive request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_q <= 1'b0;
            rx_irq_q <= 1'b0;
        end else begin
            overrun_q <= ctrl_q.continuous_rx_enable & (overrun_q | (rx_done & rx_ready_q)); // R21
            rx_irq_q <= rx_ready_q & ctrl_q.rx_irq_enable; // R19
        end
    end

    // clocks spent in the current transmitted bit
    logic [23:0] tx_clk_q;
    logic [23:0] tx_period;
    assign tx_period = 24'((div + 17'h00001) * bticks);
    always_ff @(posedge aclk) begin
        if (!aresetn || tx_load || tx_bend) begin
            tx_clk_q <= 24'h000000;
        end else begin
            tx_clk_q <= tx_clk_q + 24'h000001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_load_start;
        tx_st_q == TX_IDLE ##1 tx_st_q == TX_START;
    endsequence

    a_idle_mark: assert property ( // R1
        tx_st_q == TX_IDLE |=> tx_line_q == ~$past(tx_inv))
        else $error("idle line not at mark");
    a_start_space: assert property ( // R2
        tx_st_q == TX_START |=> tx_line_q == $past(tx_inv))
        else $error("start bit not at space");
    a_bit_period: assert property ( // R3
        tx_bend && tx_st_q != TX_IDLE && $stable(div) |-> tx_clk_q + 24'h000001 == tx_period)
        else $error("bit length wrong");
    a_lsb_first: assert property ( // R5
        tx_st_q == TX_DATA |=> tx_line_q == ($past(tx_shift_q[0]) ^ $past(tx_inv)))
        else $error("data bit order wrong");
    a_tx_gate: assert property ( // R8
        !tx_active |=> tx_st_q == TX_IDLE && !tx_full_q)
        else $error("transmitter ran while disabled");
    a_load_now: assert property ( // R9
        tx_wr && tx_active && tx_st_q == TX_IDLE && !tx_full_q ##1 tx_active |-> s_load_start)
        else $error("idle write did not start a frame");
    a_flag_set: assert property ( // R13
        (tx_active && !tx_full_q) [*2] |-> tx_flag_q)
        else $error("empty flag not set");
    a_irq_gate: assert property ( // R17
        tx_irq |-> $past(tx_flag_q) && $past(ctrl_q.tx_irq_enable))
        else $error("transmit request without enable");
    a_rx_ready: assert property ( // R19
        rx_done && !rx_ready_q && rx_keep |=> rx_ready_q && rx_buf_q == $past(rx_word[7:0]))
        else $error("received character not delivered");
    a_ovr_clear: assert property ( // R21
        !ctrl_q.continuous_rx_enable |=> !overrun_q)
        else $error("overrun not cleared");
    a_addr_drop: assert property ( // R23
        rx_done && !rx_ready_q && !rx_keep && !rx_rd |=> !rx_ready_q)
        else $error("address mode kept a data character");

endmodule

`default_nettype wire

/* File: testbench/ast_remote.sv */
// ast_remote.sv: far-end serial device that decodes tx frames and sends rx frames
// assumes: bit period in clocks given by BIT; rx line idles high, driven high from time zero
`timescale 1ns/1ps
`default_nettype none

module ast_remote #(
    parameter int BIT = 32
) (
    // clock
    input wire logic aclk,
    // serial lines and format
    input wire logic tx_line,
    input wire logic inv,
    input wire logic nine,
    output logic rx_line
);
    logic [8:0] q[$];
    int bad = 0;

    initial rx_line = 1'b1;

    // decode each frame, two samples per bit to catch period drift
    always begin : rcv
        logic [10:0] sh;
        logic a;
        bit ok;
        @(posedge aclk);
        ok = 1'b1;
        if ((tx_line ^ inv) === 1'b0) begin
            for (int i = 0; i < (nine ? 11 : 10); i++) begin
                repeat (BIT / 4 - 1) @(posedge aclk);
                a = tx_line ^ inv;
                // a space shorter than a quarter of a bit, as when polarity flips, is no frame
                if (i == 0 && a !== 1'b0) begin
                    ok = 1'b0;
                    break;
                end
                repeat (BIT / 2) @(posedge aclk);
                sh[i] = tx_line ^ inv;
                if (a !== sh[i]) bad++;
                repeat (BIT / 4 + 1) @(posedge aclk);
            end
            if (ok && (sh[0] !== 1'b0 || sh[nine ? 10 : 9] !== 1'b1)) bad++;
            if (ok) q.push_back(nine ? sh[9:1] : {1'b0, sh[8:1]});
        end
    end

    // send one frame, lsb first, single stop bit
    task automatic send(input logic [8:0] c, input bit n9);
        logic [10:0] f;
        f = n9 ? {1'b1, c, 1'b0} : {2'b11, c[7:0], 1'b0};
        for (int i = 0; i < (n9 ? 11 : 10); i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge aclk);
        end
    endtask
endmodule

`default_nettype wire

/* File: testbench/tb_top.sv */
// tb_top.sv: random and corner tests of the serial transceiver over axi4-lite
// assumes: baud divisor 1 at normal speed gives 32 clocks per bit
`timescale 1ns/1ps
`default_nettype none
`include "ast_cfg.svh"

module tb_top;
    import ast_pkg::*;
    localparam int BIT = 32;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, tx_o, rx_i, tx_irq, rx_irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic inv = 1'b0, nine = 1'b0;
    logic [8:0] a, b;
    int mismatches = 0, checks_done = 0;

    always #20 aclk = ~aclk;

    ast_uart dut(.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .tx_o(tx_o), .rx_i(rx_i), .tx_irq(tx_irq), .rx_irq(rx_irq));
    ast_remote #(.BIT(BIT)) rem(.aclk(aclk), .tx_line(tx_o), .inv(inv), .nine(nine),
        .rx_line(rx_i));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // one status bit as a word
    function automatic logic [31:0] bit_of(input logic [31:0] w, input int n);
        return {31'h0, w[n]};
    endfunction

    // expected control word from its fields
    function automatic logic [31:0] ctl(input ast_ctrl_s c);
        return {16'h0, c};
    endfunction

    task automatic wr(input logic [7:0] ad, input logic [31:0] dat, output logic [1:0] rs);
        awaddr <= ad;
        wdata <= dat;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] dat, output logic [1:0] rs);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dat = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // write the control register with a mode
    task automatic mode(input logic [15:0] m);
        wr(`AST_OFF_CTRL, {16'h0, m}, r);
        chk({30'h0, r}, {30'h0, `AST_RESP_OK});
        rd(`AST_OFF_CTRL, d, r);
        chk(d, ctl(m));
    endtask

    initial begin
        #(40 * 60000);
        mismatches++;
        final_report();
    end

    initial begin
        void'($urandom(46));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(`AST_OFF_CTRL, d, r);
        chk(d, {16'h0, `AST_CTRL_RST});
        rd(`AST_OFF_STAT, d, r);
        chk(bit_of(d, 0), 32'h0);
        rd(8'h14, d, r);
        chk({30'h0, r}, {30'h0, `AST_RESP_ERR});
        wr(`AST_OFF_BAUD, 32'h1, r);
        mode(16'h0403);
        rd(`AST_OFF_STAT, d, r);
        chk(bit_of(d, 0), 32'h1);
        chk({31'h0, tx_irq}, 32'h1);
        wr(`AST_OFF_STAT, 32'h0, r);
        chk({30'h0, r}, {30'h0, `AST_RESP_ERR});
        rd(`AST_OFF_STAT, d, r);
        chk(bit_of(d, 0), 32'h1);
        // pairs of characters, second queued behind the first, both polarities
        for (int i = 0; i < 4; i++) begin
            inv = i[0];
            nine = i[1];
            mode({8'h00, inv, 3'b000, nine, 3'b011});
            repeat (2) @(posedge aclk);
            chk({31'h0, tx_o}, {31'h0, ~inv});
            a = 9'($urandom);
            b = (i == 0) ? 9'h000 : 9'($urandom);
            if (!nine) a[8] = 1'b0;
            if (!nine) b[8] = 1'b0;
            wr(`AST_OFF_TXBUF, {23'h0, a}, r);
            wr(`AST_OFF_TXBUF, {23'h0, b}, r);
            rd(`AST_OFF_STAT, d, r);
            chk(bit_of(d, 0), 32'h0);
            wait (rem.q.size() == 2);
            chk({23'h0, rem.q.pop_front()}, {23'h0, a});
            chk({23'h0, rem.q.pop_front()}, {23'h0, b});
        end
        inv = 1'b0;
        nine = 1'b0;
        // high speed: 8-bit count ignores the upper divisor byte, then the 16-bit count
        for (int i = 0; i < 2; i++) begin
            mode(i == 0 ? 16'h0103 : 16'h0303);
            wr(`AST_OFF_BAUD, i == 0 ? 32'h0107 : 32'h0007, r);
            a = {1'b0, 8'($urandom)};
            wr(`AST_OFF_TXBUF, {23'h0, a}, r);
            wait (rem.q.size() == 1);
            chk({23'h0, rem.q.pop_front()}, {23'h0, a});
        end
        wr(`AST_OFF_BAUD, 32'h1, r);
        chk(rem.bad, 0);
        // transmitter held off without enable or in synchronous mode
        for (int i = 0; i < 2; i++) begin
            mode(i == 0 ? 16'h0001 : 16'h0007);
            wr(`AST_OFF_TXBUF, 32'h55, r);
            repeat (12 * BIT) @(posedge aclk);
            chk(rem.q.size(), 0);
        end
        // receive a random byte, reception independent of transmit
        mode(16'h0821);
        a = {1'b0, 8'($urandom)};
        rem.send(a, 1'b0);
        repeat (4) @(posedge aclk);
        chk({31'h0, rx_irq}, 32'h1);
        rd(`AST_OFF_RXBUF, d, r);
        chk(d & 32'hFF, {24'h0, a[7:0]});
        rd(`AST_OFF_STAT, d, r);
        chk(bit_of(d, 1), 32'h0);
        // overrun: two characters without a read, cleared by dropping receive
        rem.send(9'h0A5, 1'b0);
        rem.send(9'h05A, 1'b0);
        repeat (4) @(posedge aclk);
        rd(`AST_OFF_STAT, d, r);
        chk(bit_of(d, 2), 32'h1);
        mode(16'h0001);
        rd(`AST_OFF_STAT, d, r);
        chk(bit_of(d, 2), 32'h0);
        rd(`AST_OFF_RXBUF, d, r);
        // address detect keeps only ninth-bit-set characters
        mode(16'h0071);
        rem.send({1'b0, 8'($urandom)}, 1'b1);
        repeat (4) @(posedge aclk);
        rd(`AST_OFF_STAT, d, r);
        chk(bit_of(d, 1), 32'h0);
        a = {1'b1, 8'($urandom)};
        rem.send(a, 1'b1);
        repeat (4) @(posedge aclk);
        rd(`AST_OFF_STAT, d, r);
        chk(d & 32'h22, 32'h22);
        rd(`AST_OFF_RXBUF, d, r);
        chk(d & 32'hFF, {24'h0, a[7:0]});
        final_report();
    end
endmodule

`default_nettype wire
